/* ubf_defines.svh */
`ifndef UBF_DEFINES_SVH
`define UBF_DEFINES_SVH

// clock
`define UBF_CLK_NS          32'd4

// wishbone register byte offsets
`define UBF_REG_CTRL        8'h00
`define UBF_REG_BOOST_TIME  8'h04
`define UBF_REG_PROG_TIME   8'h08
`define UBF_REG_STATUS      8'h0c

// ctrl field positions
`define UBF_CTRL_BOOST_EN   0
`define UBF_CTRL_PROG_EN    1

// reset values
`define UBF_RST_TIME        8'h01
`define UBF_RST_ADDR        7'h00

// standard request codes
`define UBF_RQ_GET_STATUS   8'h00
`define UBF_RQ_CLR_FEATURE  8'h01
`define UBF_RQ_SET_FEATURE  8'h03
`define UBF_RQ_SET_ADDRESS  8'h05
`define UBF_RQ_GET_DESC     8'h06
`define UBF_RQ_GET_CONFIG   8'h08
`define UBF_RQ_SET_CONFIG   8'h09
`define UBF_RQ_GET_IFACE    8'h0a
`define UBF_RQ_SET_IFACE    8'h0b
`define UBF_DESC_DEVICE     8'h01
`define UBF_DESC_CONFIG     8'h02
`define UBF_FEAT_WAKEUP     16'h0001
`define UBF_ADDR_MAX        16'h001f
`define UBF_ALT_MAX         16'h0003

// vendor command types and commands
`define UBF_VT_CONTROL      8'h00
`define UBF_VT_COMM         8'h01
`define UBF_VT_MODE         8'h02
`define UBF_CC_HALT_DONE    16'h0001
`define UBF_CC_HALT_IDLE    16'h0002
`define UBF_CM_PULSE        16'h0030
`define UBF_CM_PULSE_PROG   16'h0031
`define UBF_MD_EN_PULSE     16'h0000
`define UBF_MD_BOOST_TIME   16'h0003
`define UBF_MD_PROG_TIME    16'h0005

// endpoint facts per alternate setting
`define UBF_EP0_PKT         7'd8
`define UBF_PKT_SMALL       7'd16
`define UBF_PKT_LARGE       7'd64
`define UBF_POLL_LONG_MS    4'd10
`define UBF_POLL_SHORT_MS   4'd1

// timing: pulse duration unit, edge ramp step, resume length
`define UBF_PULSE_UNIT_NS   32'd16000
`define UBF_PULSE_UNIT_CYC  ((`UBF_PULSE_UNIT_NS + `UBF_CLK_NS - 32'd1) / `UBF_CLK_NS)
`define UBF_RAMP_STEP_NS    32'd250
`define UBF_RAMP_STEP_CYC   ((`UBF_RAMP_STEP_NS + `UBF_CLK_NS - 32'd1) / `UBF_CLK_NS)
`define UBF_RESUME_US       32'd2000
`define UBF_RESUME_CYC      ((`UBF_RESUME_US * 32'd1000 + `UBF_CLK_NS - 32'd1) / `UBF_CLK_NS)

`endif

/* ubf_pkg.sv */
package ubf_pkg;
  typedef struct packed {
    logic [7:0]  req_type;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } ubf_setup_t;

  typedef struct packed {
    logic        stall;
    logic [1:0]  len;
    logic [15:0] data;
  } ubf_resp_t;

  typedef struct packed {
    logic       attach;
    logic       pulse_done;
    logic       refused;
    logic       pulse_busy;
    logic [3:0] alt;
  } ubf_ep1_t;

  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001,
    PS_RISE = 4'b0010,
    PS_HOLD = 4'b0100,
    PS_FALL = 4'b1000
  } ubf_pulse_st_t;
endpackage

/* ubf_core.sv */
// The register addresses and the Wishbone register port were chosen for this implementation.
`include "ubf_defines.svh"

// Operation
// R1 - pulse command drives either 5V boost pullup or 12V programming pulse
// R2 - boost timed from boost setting, programming pulse from its own setting
// R3 - host ends infinite pulses with halt-when-done or halt-when-idle
// R4 - both programming pulse edges are ramped in controlled slew steps
// R5 - all commands on endpoint 0, data and status on bulk and interrupt
// R6 - host toggles remote wake-up, cleared at power-up and device reset
// R7 - suspended with wake-up enabled, slave attach triggers resume signaling
// R8 - endpoint 1 interrupt IN reports status, completion, errors and attach
// R9 - interrupt poll period 10 ms by default, 1 ms for short settings
// R10 - endpoint 2 bulk OUT bytes go onto the single-wire bus
// R11 - endpoint 3 bulk IN returns bytes read from the single-wire bus
// R12 - alt 0..3 give 10/16, 10/64, 1/16, 1/64 poll ms and packet bytes
// R13 - only configuration 0 and 1 accepted, 0 means unconfigured
// R14 - get-descriptor only for device and configuration types
// R15 - interface 0 only, alternate settings 0 to 3
// R16 - set/clear feature only for device remote wake-up
// R17 - device status: self-powered zero, wake-up bit shows enable
// R18 - interface status always all zero
// R19 - undefined vendor requests are stalled
// R20 - address 1..31 only, endpoint 0 packet 8 bytes in every setting
module ubf_core
  import ubf_pkg::*;
#(
  parameter int unsigned RESUME_CYC = `UBF_RESUME_CYC,
  parameter int unsigned RAMP_STEPS = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        usb_reset_i,
  input  wire logic        suspend_i,
  input  wire logic        setup_valid_i,
  input  wire ubf_setup_t  setup_i,
  output logic             resp_valid_o,
  output ubf_resp_t        resp_o,
  output logic [6:0]       dev_addr_o,
  output logic [6:0]       ep0_pkt_o,
  output logic [6:0]       bulk_pkt_o,
  output logic [3:0]       ep1_poll_ms_o,
  output logic             ep1_valid_o,
  output ubf_ep1_t         ep1_o,
  input  wire logic        ep1_ready_i,
  input  wire logic        ep2_valid_i,
  input  wire logic [7:0]  ep2_data_i,
  output logic             ep2_ready_o,
  output logic             wire_tx_valid_o,
  output logic [7:0]       wire_tx_data_o,
  input  wire logic        wire_tx_ready_i,
  input  wire logic        wire_rx_valid_i,
  input  wire logic [7:0]  wire_rx_data_i,
  output logic             wire_rx_ready_o,
  output logic             ep3_valid_o,
  output logic [7:0]       ep3_data_o,
  input  wire logic        ep3_ready_i,
  input  wire logic        attach_i,
  output logic             resume_o,
  output logic             boost_en_o,
  output logic             prog_en_o,
  output logic [3:0]       prog_level_o
);

  localparam logic [31:0] UNIT_CYC = `UBF_PULSE_UNIT_CYC;
  localparam logic [31:0] STEP_CYC = `UBF_RAMP_STEP_CYC;

  function automatic logic is_std(input ubf_setup_t s);
    return s.req_type[6:5] == 2'b00;
  endfunction

  function automatic logic is_vnd(input ubf_setup_t s);
    return s.req_type[6:5] == 2'b10;
  endfunction

  // state
  logic [7:0]    boost_time_r, prog_time_r;
  logic          boost_ok_r, prog_ok_r;
  logic          wake_en_r, configured_r;
  logic [1:0]    alt_r;
  logic [6:0]    addr_r;
  ubf_pulse_st_t ps_r, ps_nxt;
  logic          ps_prog_r;
  logic [7:0]    units_r;
  logic [31:0]   cyc_r;
  logic [3:0]    level_r;
  logic          halt_r;
  logic [2:0]    att_sync_r;
  logic          att_lvl_r;
  logic [31:0]   res_cnt_r;
  logic          ev_att_r, ev_done_r, ev_ref_r;

  // wishbone decode
  wire wb_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr     = wb_hit & wb_we_i & wb_sel_i[0];
  wire wr_ctrl   = wb_wr & (wb_adr_i == `UBF_REG_CTRL);
  wire wr_boost  = wb_wr & (wb_adr_i == `UBF_REG_BOOST_TIME);
  wire wr_prog   = wb_wr & (wb_adr_i == `UBF_REG_PROG_TIME);
  wire [31:0] rd_mux =
    (wb_adr_i == `UBF_REG_CTRL)       ? {30'h0, prog_ok_r, boost_ok_r} :
    (wb_adr_i == `UBF_REG_BOOST_TIME) ? {24'h0, boost_time_r} :
    (wb_adr_i == `UBF_REG_PROG_TIME)  ? {24'h0, prog_time_r} :
    (wb_adr_i == `UBF_REG_STATUS)     ? {16'h0, 1'b0, addr_r, ps_prog_r,
                                         ps_r != PS_IDLE, att_lvl_r,
                                         wake_en_r, configured_r, 1'b0, alt_r}
                                      : 32'h0;

  // setup request decode, endpoint 0 only carries these
  wire sv        = setup_valid_i; // R5
  wire rcp_dev   = setup_i.req_type[4:0] == 5'h00;
  wire rcp_if    = setup_i.req_type[4:0] == 5'h01;
  wire if0       = setup_i.index == 16'h0000; // R15
  wire std_req   = sv & is_std(setup_i);
  wire vnd_req   = sv & is_vnd(setup_i);
  wire rq_gsts   = std_req & setup_i.request == `UBF_RQ_GET_STATUS;
  wire rq_feat   = std_req & rcp_dev & setup_i.value == `UBF_FEAT_WAKEUP & // R16
                   (setup_i.request == `UBF_RQ_SET_FEATURE |
                    setup_i.request == `UBF_RQ_CLR_FEATURE);
  wire rq_addr   = std_req & setup_i.request == `UBF_RQ_SET_ADDRESS &
                   setup_i.value != 16'h0 & setup_i.value <= `UBF_ADDR_MAX; // R20
  wire rq_desc   = std_req & setup_i.request == `UBF_RQ_GET_DESC &
                   (setup_i.value[15:8] == `UBF_DESC_DEVICE |
                    setup_i.value[15:8] == `UBF_DESC_CONFIG); // R14
  wire rq_gcfg   = std_req & setup_i.request == `UBF_RQ_GET_CONFIG;
  wire rq_scfg   = std_req & setup_i.request == `UBF_RQ_SET_CONFIG &
                   setup_i.value <= 16'h0001; // R13
  wire rq_gif    = std_req & rcp_if & if0 & setup_i.request == `UBF_RQ_GET_IFACE;
  wire rq_sif    = std_req & rcp_if & if0 & setup_i.request == `UBF_RQ_SET_IFACE &
                   setup_i.value <= `UBF_ALT_MAX; // R15
  wire vc_halt   = vnd_req & setup_i.request == `UBF_VT_CONTROL &
                   (setup_i.value == `UBF_CC_HALT_DONE |
                    setup_i.value == `UBF_CC_HALT_IDLE); // R3
  wire vc_pulse  = vnd_req & setup_i.request == `UBF_VT_COMM &
                   (setup_i.value == `UBF_CM_PULSE |
                    setup_i.value == `UBF_CM_PULSE_PROG);
  wire pulse_sel = setup_i.value == `UBF_CM_PULSE_PROG;
  wire pulse_ok  = vc_pulse & ps_r == PS_IDLE &
                   (pulse_sel ? prog_ok_r : boost_ok_r);
  wire vm_en     = vnd_req & setup_i.request == `UBF_VT_MODE &
                   setup_i.value == `UBF_MD_EN_PULSE;
  wire vm_bt     = vnd_req & setup_i.request == `UBF_VT_MODE &
                   setup_i.value == `UBF_MD_BOOST_TIME;
  wire vm_pt     = vnd_req & setup_i.request == `UBF_VT_MODE &
                   setup_i.value == `UBF_MD_PROG_TIME;
  wire rq_ok     = rq_gsts | rq_feat | rq_addr | rq_desc | rq_gcfg | rq_scfg |
                   rq_gif | rq_sif | vc_halt | pulse_ok | vm_en | vm_bt | vm_pt; // R19
  wire [15:0] sts_data = rcp_dev ? {14'h0, wake_en_r, 1'b0} : 16'h0000; // R17 R18
  wire [15:0] rsp_data =
    rq_gsts ? sts_data :
    rq_gcfg ? {15'h0, configured_r} :
    rq_gif  ? {14'h0, alt_r} :
    rq_desc ? {8'h0, setup_i.value[15:8]} : 16'h0000;
  wire [1:0] rsp_len = rq_gsts ? 2'd2 : (rq_gcfg | rq_gif | rq_desc) ? 2'd1 : 2'd0;

  // wishbone slave, one wait-free ack cycle, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_mux : 32'h0;
    end
  end

  // pulse settings, from software or mode commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_ok_r   <= 1'b0;
      prog_ok_r    <= 1'b0;
      boost_time_r <= `UBF_RST_TIME;
      prog_time_r  <= `UBF_RST_TIME;
    end else begin
      if (vm_en) begin
        boost_ok_r <= setup_i.index[`UBF_CTRL_BOOST_EN];
        prog_ok_r  <= setup_i.index[`UBF_CTRL_PROG_EN];
      end else if (wr_ctrl) begin
        boost_ok_r <= wb_dat_i[`UBF_CTRL_BOOST_EN];
        prog_ok_r  <= wb_dat_i[`UBF_CTRL_PROG_EN];
      end
      if (vm_bt) boost_time_r <= setup_i.index[7:0];
      else if (wr_boost) boost_time_r <= wb_dat_i[7:0];
      if (vm_pt) prog_time_r <= setup_i.index[7:0];
      else if (wr_prog) prog_time_r <= wb_dat_i[7:0];
    end
  end

  // usb device state and request answers
  always_ff @(posedge clk_i) begin
    if (rst_i || usb_reset_i) begin
      wake_en_r    <= 1'b0; // R6
      configured_r <= 1'b0;
      alt_r        <= 2'd0;
      addr_r       <= `UBF_RST_ADDR;
      resp_valid_o <= 1'b0;
      resp_o       <= '0;
    end else begin
      resp_valid_o <= sv;
      resp_o       <= '{stall: ~rq_ok, len: rsp_len, data: rsp_data};
      if (rq_feat) wake_en_r <= setup_i.request == `UBF_RQ_SET_FEATURE; // R6
      if (rq_addr) addr_r <= setup_i.value[6:0]; // R20
      if (rq_scfg) configured_r <= setup_i.value[0]; // R13
      if (rq_sif) alt_r <= setup_i.value[1:0]; // R12
    end
  end

  // endpoint geometry per alternate setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep0_pkt_o     <= `UBF_EP0_PKT;
      bulk_pkt_o    <= `UBF_PKT_SMALL;
      ep1_poll_ms_o <= `UBF_POLL_LONG_MS;
      dev_addr_o    <= `UBF_RST_ADDR;
    end else begin
      ep0_pkt_o     <= `UBF_EP0_PKT; // R20
      bulk_pkt_o    <= alt_r[0] ? `UBF_PKT_LARGE : `UBF_PKT_SMALL; // R12
      ep1_poll_ms_o <= alt_r[1] ? `UBF_POLL_SHORT_MS : `UBF_POLL_LONG_MS; // R9
      dev_addr_o    <= addr_r;
    end
  end

  // pulse engine; a zero duration setting means infinite
  wire [7:0] dur      = ps_prog_r ? prog_time_r : boost_time_r; // R2
  wire       unit_end = cyc_r == UNIT_CYC - 32'd1;
  wire       step_end = cyc_r == STEP_CYC - 32'd1;
  wire       hold_end = (dur != 8'h0 & unit_end & units_r == dur - 8'd1) | halt_r;
  wire       top      = level_r == 4'(RAMP_STEPS - 1);

  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      PS_IDLE: if (pulse_ok) ps_nxt = pulse_sel ? PS_RISE : PS_HOLD; // R1
      PS_RISE: if (step_end & top) ps_nxt = PS_HOLD; // R4
      PS_HOLD: if (hold_end) ps_nxt = ps_prog_r ? PS_FALL : PS_IDLE;
      PS_FALL: if (step_end & level_r == 4'd0) ps_nxt = PS_IDLE; // R4
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_r      <= PS_IDLE;
      ps_prog_r <= 1'b0;
      cyc_r     <= 32'h0;
      units_r   <= 8'h0;
      level_r   <= 4'h0;
      halt_r    <= 1'b0;
    end else begin
      ps_r   <= ps_nxt;
      halt_r <= vc_halt & ps_r == PS_HOLD; // R3
      if (ps_r == PS_IDLE) ps_prog_r <= pulse_sel;
      cyc_r  <= (ps_nxt != ps_r | unit_end | step_end & ps_r != PS_HOLD) ? 32'h0
                : cyc_r + 32'd1;
      if (ps_r != PS_HOLD) units_r <= 8'h0;
      else if (unit_end) units_r <= units_r + 8'd1;
      if (ps_r == PS_RISE & step_end & ~top) level_r <= level_r + 4'd1;
      else if (ps_r == PS_FALL & step_end & level_r != 4'd0) level_r <= level_r - 4'd1;
    end
  end

  // pin drives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_en_o   <= 1'b0;
      prog_en_o    <= 1'b0;
      prog_level_o <= 4'h0;
    end else begin
      boost_en_o   <= ps_nxt == PS_HOLD & ~(ps_r == PS_IDLE ? pulse_sel : ps_prog_r); // R1
      prog_en_o    <= ps_nxt != PS_IDLE & (ps_r == PS_IDLE ? pulse_sel : ps_prog_r); // R1
      prog_level_o <= level_r; // R4
    end
  end

  // attach pin sync, change taken when stages two and three agree
  wire att_rise = ~att_lvl_r & att_sync_r[1] & att_sync_r[2];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      att_sync_r <= 3'b000;
      att_lvl_r  <= 1'b0;
      res_cnt_r  <= 32'h0;
      resume_o   <= 1'b0;
    end else begin
      att_sync_r <= {att_sync_r[1:0], attach_i};
      if (att_sync_r[1] == att_sync_r[2]) att_lvl_r <= att_sync_r[2];
      if (att_rise & wake_en_r & suspend_i & res_cnt_r == 32'h0)
        res_cnt_r <= RESUME_CYC; // R7
      else if (res_cnt_r != 32'h0)
        res_cnt_r <= res_cnt_r - 32'd1;
      resume_o <= res_cnt_r != 32'h0;
    end
  end

  // interrupt endpoint report; a new event beats the clear on hand-off
  wire ep1_take = ep1_valid_o & ep1_ready_i;
  wire done_ev  = ps_r != PS_IDLE & ps_nxt == PS_IDLE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_att_r    <= 1'b0;
      ev_done_r   <= 1'b0;
      ev_ref_r    <= 1'b0;
      ep1_valid_o <= 1'b0;
      ep1_o       <= '0;
    end else begin
      ev_att_r  <= att_rise | (ev_att_r & ~(ep1_take & ep1_o.attach)); // R8
      ev_done_r <= done_ev | (ev_done_r & ~(ep1_take & ep1_o.pulse_done)); // R8
      ev_ref_r  <= (sv & ~rq_ok) | (ev_ref_r & ~(ep1_take & ep1_o.refused)); // R8
      ep1_valid_o <= configured_r & ~ep1_take &
                     (ev_att_r | ev_done_r | ev_ref_r | ep1_valid_o);
      if (~ep1_valid_o | ep1_take)
        ep1_o <= '{attach: ev_att_r, pulse_done: ev_done_r, refused: ev_ref_r,
                   pulse_busy: ps_r != PS_IDLE, alt: {2'b00, alt_r}};
    end
  end

  // bulk out to wire, one byte held in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wire_tx_valid_o <= 1'b0;
      wire_tx_data_o  <= 8'h0;
      ep2_ready_o     <= 1'b0;
    end else begin
      if (ep2_valid_i & ep2_ready_o) begin
        wire_tx_valid_o <= 1'b1; // R10
        wire_tx_data_o  <= ep2_data_i;
      end else if (wire_tx_ready_i) begin
        wire_tx_valid_o <= 1'b0;
      end
      ep2_ready_o <= configured_r & ~(ep2_valid_i & ep2_ready_o) &
                     (~wire_tx_valid_o | wire_tx_ready_i);
    end
  end

  // wire to bulk in, one byte held in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep3_valid_o     <= 1'b0;
      ep3_data_o      <= 8'h0;
      wire_rx_ready_o <= 1'b0;
    end else begin
      if (wire_rx_valid_i & wire_rx_ready_o) begin
        ep3_valid_o <= 1'b1; // R11
        ep3_data_o  <= wire_rx_data_i;
      end else if (ep3_ready_i) begin
        ep3_valid_o <= 1'b0;
      end
      wire_rx_ready_o <= configured_r & ~(wire_rx_valid_i & wire_rx_ready_o) &
                         (~ep3_valid_o | ep3_ready_i);
    end
  end

endmodule

/* ubf_core_sva.sv */
module ubf_core_chk #(
  parameter int unsigned RESUME_CYC = 50
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       usb_reset_i,
  input wire logic       suspend_i,
  input wire logic       setup_valid_i,
  input wire logic       resp_valid_o,
  input wire logic [6:0] ep0_pkt_o,
  input wire logic [6:0] bulk_pkt_o,
  input wire logic [3:0] ep1_poll_ms_o,
  input wire logic       resume_o,
  input wire logic       boost_en_o,
  input wire logic       prog_en_o,
  input wire logic [3:0] prog_level_o
);
  logic [31:0] res_cnt_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // length of the resume burst so far
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_cnt_r <= 32'h0;
    end else begin
      res_cnt_r <= resume_o ? res_cnt_r + 32'h1 : 32'h0;
    end
  end

  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus cycle not acked");
  resp_lat_a: assert property (setup_valid_i && !usb_reset_i |=> resp_valid_o)
    else $error("no response after setup");
  resp_cause_a: assert property ($rose(resp_valid_o) |-> $past(setup_valid_i))
    else $error("response without setup");
  ep0_size_a: assert property (ep0_pkt_o == 7'd8)
    else $error("control packet size wrong");
  bulk_size_a: assert property (bulk_pkt_o == 7'd16 || bulk_pkt_o == 7'd64)
    else $error("bulk packet size wrong");
  poll_val_a: assert property (ep1_poll_ms_o == 4'd10 || ep1_poll_ms_o == 4'd1)
    else $error("poll period wrong");
  pulse_excl_a: assert property (!(boost_en_o && prog_en_o))
    else $error("both pulse paths on");
  resume_cause_a: assert property ($rose(resume_o) |-> $past(suspend_i))
    else $error("resume while not suspended");
  resume_len_a: assert property ($fell(resume_o) |-> res_cnt_r == RESUME_CYC)
    else $error("resume length wrong");
  ramp_step_a: assert property ($changed(prog_level_o) |->
    (prog_level_o - $past(prog_level_o) == 4'h1) ||
    ($past(prog_level_o) - prog_level_o == 4'h1))
    else $error("ramp jumped");
  ramp_gate_a: assert property (prog_level_o != 4'h0 |-> prog_en_o)
    else $error("ramp level without prog path");

  boost_c: cover property ($rose(boost_en_o));
  prog_top_c: cover property (prog_level_o == 4'h3);
  resume_c: cover property ($rose(resume_o));
endmodule

bind ubf_core ubf_core_chk #(.RESUME_CYC(RESUME_CYC)) CHK (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .usb_reset_i(usb_reset_i), .suspend_i(suspend_i),
  .setup_valid_i(setup_valid_i), .resp_valid_o(resp_valid_o), .ep0_pkt_o(ep0_pkt_o),
  .bulk_pkt_o(bulk_pkt_o), .ep1_poll_ms_o(ep1_poll_ms_o), .resume_o(resume_o),
  .boost_en_o(boost_en_o), .prog_en_o(prog_en_o), .prog_level_o(prog_level_o)
);

/* ubf_host_model.sv */
module ubf_host_model
  import ubf_pkg::*;
(
  input  wire logic       clk_i,
  output logic            setup_valid_o,
  output ubf_setup_t      setup_o,
  input  wire logic       resp_valid_i,
  input  wire ubf_resp_t  resp_i,
  input  wire logic       ep1_valid_i,
  input  wire ubf_ep1_t   ep1_i,
  output logic            ep1_ready_o,
  output logic            ep3_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ubf_ep1_t last_ep1;
  logic     slow;
  int       misses = 0;

  initial begin
    setup_valid_o = 1'b0;
    setup_o = '0;
    slow = 1'b0;
    last_ep1 = '0;
  end

  // host takes reports and bulk bytes every other cycle
  assign ep1_ready_o = slow;
  assign ep3_ready_o = ~slow;
  always @(posedge clk_i) begin
    slow <= ~slow;
    if (ep1_valid_i && ep1_ready_o) begin
      last_ep1 <= ep1_i;
    end
  end

  // one control request on the default pipe, waits for its answer
  task automatic req(input ubf_setup_t s, output ubf_resp_t r);
    int k;
    @(posedge clk_i);
    setup_valid_o <= 1'b1;
    setup_o <= s;
    @(posedge clk_i);
    setup_valid_o <= 1'b0;
    setup_o <= ~s;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (resp_valid_i !== 1'b1 && k < 8);
    if (resp_valid_i !== 1'b1) misses++;
    r = resp_i;
  endtask

  // ends an open-ended pulse
  task automatic halt(output ubf_resp_t r);
    req('{8'h40, 8'h00, 16'h0001, 16'h0000, 16'h0000}, r);
  endtask
endmodule

/* usb_bridge_device_function_tb_top.sv */
module usb_bridge_device_function_tb_top
  import ubf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic        usb_rst = 1'b0;
  logic        susp = 1'b0;
  logic        attach = 1'b0;
  logic        e2_v = 1'b0;
  logic        rx_v = 1'b0;
  logic [7:0]  e2_d = 8'h00;
  logic [7:0]  rx_d = 8'h00;
  wire logic [31:0] rdat;
  wire logic   ack, sv, rv, e1_v, e1_r, e3_v, e3_r, e2_r, tx_v, rx_r, resume, boost, prog;
  wire ubf_setup_t su;
  wire ubf_resp_t  rsp;
  wire ubf_ep1_t   e1;
  wire logic [6:0] addr, e0p, bp;
  wire logic [3:0] poll, lvl;
  wire logic [7:0] tx_d, e3_d;
  ubf_resp_t   rs;
  int          num_errors = 0;
  int          checks = 0;
  int          n;

  always #2 clk_i = ~clk_i;

  ubf_core #(.RESUME_CYC(50), .RAMP_STEPS(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
    .usb_reset_i(usb_rst), .suspend_i(susp), .setup_valid_i(sv), .setup_i(su),
    .resp_valid_o(rv), .resp_o(rsp), .dev_addr_o(addr), .ep0_pkt_o(e0p),
    .bulk_pkt_o(bp), .ep1_poll_ms_o(poll), .ep1_valid_o(e1_v), .ep1_o(e1),
    .ep1_ready_i(e1_r), .ep2_valid_i(e2_v), .ep2_data_i(e2_d), .ep2_ready_o(e2_r),
    .wire_tx_valid_o(tx_v), .wire_tx_data_o(tx_d), .wire_tx_ready_i(1'b1),
    .wire_rx_valid_i(rx_v), .wire_rx_data_i(rx_d), .wire_rx_ready_o(rx_r),
    .ep3_valid_o(e3_v), .ep3_data_o(e3_d), .ep3_ready_i(e3_r), .attach_i(attach),
    .resume_o(resume), .boost_en_o(boost), .prog_en_o(prog), .prog_level_o(lvl)
  );

  ubf_host_model HOST (
    .clk_i(clk_i), .setup_valid_o(sv), .setup_o(su), .resp_valid_i(rv), .resp_i(rsp),
    .ep1_valid_i(e1_v), .ep1_i(e1), .ep1_ready_o(e1_r), .ep3_ready_o(e3_r)
  );

  task automatic summarize;
    if (num_errors == 0 && checks > 0 && HOST.misses == 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return boost;
      1: return prog;
      2: return resume;
      3: return tx_v;
      4: return e3_v;
      5: return e2_r;
      6: return rx_r;
      default: return lvl == 4'h3;
    endcase
  endfunction

  // bounded wait for a design output to reach a level
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      summarize();
    end
  endtask

  // classic wishbone single cycle, released after the acked edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
    rd = rdat;
    cyc <= 1'b0;
    wdat <= ~d;
  endtask

  task automatic u(input logic [7:0] t, input logic [7:0] q, input logic [15:0] v,
                   input logic [15:0] i);
    HOST.req('{t, q, v, i, 16'h0000}, rs);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("ep0_pkt", 32'd8, {25'h0, e0p});
    chk("bulk_pkt", 32'd16, {25'h0, bp});
    chk("poll", 32'd10, {28'h0, poll});
    wb(8'h04, 1'b0, 32'h0);
    chk("boost_time", 32'h1, rd);
    wb(8'h08, 1'b0, 32'h0);
    chk("prog_time", 32'h1, rd);
    wb(8'h10, 1'b1, 32'hff);
    wb(8'h10, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(8'h00, 1'b1, 32'h3);
    wb(8'h00, 1'b0, 32'h0);
    chk("ctrl", 32'h3, rd);
    // standard requests, then one undefined vendor request
    u(8'h80, 8'h00, 16'h0, 16'h0);
    chk("dev_status", 32'h20000, {14'h0, rsp.len, rs.data});
    u(8'h00, 8'h03, 16'h0001, 16'h0);
    u(8'h80, 8'h00, 16'h0, 16'h0);
    chk("wake_on", 32'h2, {16'h0, rs.data});
    u(8'h00, 8'h03, 16'h0002, 16'h0);
    chk("bad_feature", 32'h1, {31'h0, rs.stall});
    @(posedge clk_i);
    usb_rst <= 1'b1;
    @(posedge clk_i);
    usb_rst <= 1'b0;
    u(8'h80, 8'h00, 16'h0, 16'h0);
    chk("wake_reset", 32'h0, {16'h0, rs.data});
    u(8'h00, 8'h05, 16'h0020, 16'h0);
    chk("addr_range", 32'h1, {31'h0, rs.stall});
    u(8'h00, 8'h05, 16'h001f, 16'h0);
    @(negedge clk_i);
    chk("addr", 32'h1f, {25'h0, addr});
    u(8'h00, 8'h09, 16'h0002, 16'h0);
    chk("cfg_range", 32'h1, {31'h0, rs.stall});
    u(8'h00, 8'h09, 16'h0001, 16'h0);
    u(8'h80, 8'h08, 16'h0, 16'h0);
    chk("cfg", 32'h1, {16'h0, rs.data});
    for (int a = 0; a < 4; a++) begin
      u(8'h01, 8'h0b, 16'(a), 16'h0);
      u(8'h81, 8'h0a, 16'h0, 16'h0);
      chk("alt", a, {16'h0, rs.data});
      chk("alt_pkt", a[0] ? 32'd64 : 32'd16, {25'h0, bp});
      chk("alt_poll", a[1] ? 32'd1 : 32'd10, {28'h0, poll});
    end
    u(8'h01, 8'h0b, 16'h0004, 16'h0);
    chk("alt_range", 32'h1, {31'h0, rs.stall});
    for (int t = 1; t < 4; t++) begin
      u(8'h80, 8'h06, {8'(t), 8'h00}, 16'h0);
      chk("desc", t == 3, {31'h0, rs.stall});
    end
    u(8'h81, 8'h00, 16'h0, 16'h0);
    chk("if_status", 32'h0, {16'h0, rs.data});
    u(8'hc0, 8'h07, 16'h0, 16'h0);
    chk("vendor_bad", 32'h1, {31'h0, rs.stall});
    // bulk bytes in both directions
    @(posedge clk_i);
    e2_v <= 1'b1;
    e2_d <= 8'ha5;
    wt(5, 1'b1, 20);
    @(posedge clk_i);
    e2_v <= 1'b0;
    e2_d <= 8'h5a;
    wt(3, 1'b1, 20);
    chk("tx_byte", 32'ha5, {24'h0, tx_d});
    @(posedge clk_i);
    rx_v <= 1'b1;
    rx_d <= 8'h3c;
    wt(6, 1'b1, 20);
    @(posedge clk_i);
    rx_v <= 1'b0;
    rx_d <= 8'hc3;
    wt(4, 1'b1, 20);
    chk("ep3_byte", 32'h3c, {24'h0, e3_d});
    // timed boost, then open-ended programming pulse
    u(8'h40, 8'h02, 16'h0000, 16'h0003);
    u(8'h40, 8'h02, 16'h0003, 16'h0001);
    u(8'h40, 8'h02, 16'h0005, 16'h0000);
    u(8'h40, 8'h01, 16'h0030, 16'h0);
    wt(0, 1'b1, 10);
    n = 0;
    while (boost === 1'b1 && n < 4100) begin
      @(negedge clk_i);
      n++;
    end
    chk("boost_len", 32'd4000, n);
    u(8'h40, 8'h01, 16'h0031, 16'h0);
    wt(1, 1'b1, 10);
    chk("prog_only", 32'h0, {31'h0, boost});
    wt(7, 1'b1, 400);
    repeat (100) @(posedge clk_i);
    chk("prog_held", 32'h1, {31'h0, prog});
    HOST.halt(rs);
    wt(1, 1'b0, 400);
    chk("ramp_down", 32'h0, {28'h0, lvl});
    // attach while suspended with wake-up on
    u(8'h00, 8'h03, 16'h0001, 16'h0);
    @(posedge clk_i);
    susp <= 1'b1;
    attach <= 1'b1;
    wt(2, 1'b1, 20);
    wt(2, 1'b0, 100);
    @(posedge clk_i);
    susp <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("ep1_attach", 32'h1, {31'h0, HOST.last_ep1.attach});
    summarize();
  end
endmodule
